// ---- core/reference_switch_stop_logic.sv ----
// Top: reference switch, virtual limit and stall stop logic with registers
`timescale 1ns/1ps
// Operation
// - Bits 0/1 enable left/right stop inputs
// - Bits 2/3 select low-active switch polarity
// - Bit 4 exchanges switch direction roles
// - Bit 5 clear: velocity cut immediately
// - Bit 5 set: linear ramp stop
// - Bits 6/7 enable virtual position limits
// - Virtual limit stops at position, never crossing
// - Limit positions write-only at 0x42/0x43
// - Bit 8: latch on left activation
// - Bit 9: latch on left deactivation
// - Bits 10/11: latch on right edges
// - Bit 12 also latches encoder position
// - Bit 13 stops motor on driver stall
// - Seven-bit status word at 0x41
// - Latch-ready flags set on capture, clear on read
// - Stall event flag set, cleared on read
module reference_switch_stop_logic
   import refsw_pkg::*;
#(
   parameter int POS_WIDTH = 32
) (
   input  wire logic                     SYS_CLK_IN,
   input  wire logic                     RST_B_IN,
   // Register access from the host interface
   input  wire refsw_pkg::reg_req_type   REG_REQ_IN,
   output logic [31:0]                   REG_RDATA_OUT,
   // Switch pins and driver stall line, synchronous to the clock
   input  wire logic                     STOP_LEFT_IN,
   input  wire logic                     STOP_RIGHT_IN,
   input  wire logic                     DRIVER_STALL_IN,
   // Motion state and positions from the ramp generator
   input  wire logic                     DIR_NEGATIVE_IN,
   input  wire logic                     MOVING_IN,
   input  wire logic [POS_WIDTH-1:0]     RAMP_POS_IN,
   input  wire logic [POS_WIDTH-1:0]     ENC_POS_IN,
   input  wire logic [POS_WIDTH-1:0]     STOP_DIST_IN,
   // Stop command and latched positions
   output refsw_pkg::motion_cmd_type     MOTION_CMD_OUT,
   output logic [POS_WIDTH-1:0]          RAMP_LATCH_OUT,
   output logic [POS_WIDTH-1:0]          ENC_LATCH_OUT,
   output logic                          LATCH_STROBE_OUT
);
   import refsw_pkg::*;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   // Host-visible registers
   logic [CONFIG_WIDTH-1:0] config_q;
   logic [POS_WIDTH-1:0]    limit_left_q;
   logic [POS_WIDTH-1:0]    limit_right_q;
   // Sticky status flags
   logic                    latch_left_q;
   logic                    latch_right_q;
   logic                    stall_evt_q;
   // Captured positions, registered outputs, capture hold-off
   logic [POS_WIDTH-1:0]    ramp_latch_q;
   logic [POS_WIDTH-1:0]    enc_latch_q;
   logic                    strobe_q;
   logic [31:0]             rdata_q;
   motion_cmd_type          cmd_q;
   logic [1:0]              pol_flip_q;

   // ---------------------------------------------------------------
   // Switch conditioning
   // ---------------------------------------------------------------
   // Conditioned levels and edges; an edge shows in the same cycle the
   // pin moves, compared with the earlier level held in a flip-flop
   logic left_act;
   logic left_rise;
   logic left_fall;
   logic right_act;
   logic right_rise;
   logic right_fall;

   refsw_edge left_edge (
      .SYS_CLK_IN (SYS_CLK_IN),
      .RST_B_IN   (RST_B_IN),
      .raw_in     (STOP_LEFT_IN),
      .invert_in  (config_q[CFG_POL_LEFT]),
      .active_out (left_act),
      .rise_out   (left_rise),
      .fall_out   (left_fall)
   );

   refsw_edge right_edge (
      .SYS_CLK_IN (SYS_CLK_IN),
      .RST_B_IN   (RST_B_IN),
      .raw_in     (STOP_RIGHT_IN),
      .invert_in  (config_q[CFG_POL_RIGHT]),
      .active_out (right_act),
      .rise_out   (right_rise),
      .fall_out   (right_fall)
   );

   // ---------------------------------------------------------------
   // Register decode
   // ---------------------------------------------------------------
   // Address match of one access strobe against one register
   function automatic logic access_hit(
      input logic       strobe,
      input logic [6:0] addr,
      input logic [6:0] target
   );
      return strobe && (addr == target);
   endfunction : access_hit

   // One select per register and direction; the status word has no
   // write path and the limit words have no read path
   wire wr_config =
      access_hit(REG_REQ_IN.wr, REG_REQ_IN.addr, ADDR_CONFIG);
   wire wr_lim_l  =
      access_hit(REG_REQ_IN.wr, REG_REQ_IN.addr, ADDR_LIMIT_LEFT);
   wire wr_lim_r  =
      access_hit(REG_REQ_IN.wr, REG_REQ_IN.addr, ADDR_LIMIT_RIGHT);
   wire rd_flags  =
      access_hit(REG_REQ_IN.rd, REG_REQ_IN.addr, ADDR_FLAGS);
   wire rd_config =
      access_hit(REG_REQ_IN.rd, REG_REQ_IN.addr, ADDR_CONFIG);

   // ---------------------------------------------------------------
   // Stop decisions
   // ---------------------------------------------------------------
   // Enabled switch levels
   wire left_en  = left_act & config_q[CFG_EN_LEFT];
   wire right_en = right_act & config_q[CFG_EN_RIGHT];

   // Switch that guards each direction, exchangeable. Only the switch
   // ahead of the motion stops it, so the axis can drive off a switch
   // that it rests on
   wire neg_guard = config_q[CFG_EXCHANGE] ? right_en : left_en;
   wire pos_guard = config_q[CFG_EXCHANGE] ? left_en : right_en;
   wire switch_hit = MOVING_IN &&
                     (DIR_NEGATIVE_IN ? neg_guard : pos_guard);

   // Virtual limits: begin ramp once remaining distance is within the
   // braking distance, hard halt if already at or past the limit.
   // Differences are two's complement, so a limit across a position
   // wrap still compares correctly within half the range. A limit
   // only guards the direction that moves toward it.
   wire signed [POS_WIDTH-1:0] dist_left  =
      $signed(RAMP_POS_IN) - $signed(limit_left_q);
   wire signed [POS_WIDTH-1:0] dist_right =
      $signed(limit_right_q) - $signed(RAMP_POS_IN);
   wire lim_l_on = config_q[CFG_LIM_LEFT]  && MOVING_IN &&
                   DIR_NEGATIVE_IN;
   wire lim_r_on = config_q[CFG_LIM_RIGHT] && MOVING_IN &&
                   !DIR_NEGATIVE_IN;
   wire lim_l_at = lim_l_on && dist_left  <= 0;
   wire lim_r_at = lim_r_on && dist_right <= 0;
   wire lim_l_near = lim_l_on &&
                     dist_left  <= $signed(STOP_DIST_IN);
   wire lim_r_near = lim_r_on &&
                     dist_right <= $signed(STOP_DIST_IN);

   // Stall stop: the driver's indication acts only when enabled
   wire stall_hit = config_q[CFG_STALL_HALT] && DRIVER_STALL_IN;

   // Command selection. Standing at or past a limit cuts velocity at
   // once, as the limit must never be crossed; a switch or stall stop
   // follows the ramped-halt bit; an approaching limit only ramps
   // down. The priority keeps the harder action when causes overlap,
   // and the command returns to run as soon as no cause remains.
   motion_cmd_type cmd_d;
   always_comb begin
      cmd_d = MOTION_RUN;
      if (lim_l_at || lim_r_at) begin
         cmd_d = MOTION_HARD_STOP;
      end else if (switch_hit || stall_hit) begin
         cmd_d = config_q[CFG_RAMPED_HALT] ? MOTION_RAMP_STOP
                                           : MOTION_HARD_STOP;
      end else if (lim_l_near || lim_r_near) begin
         cmd_d = MOTION_RAMP_STOP;
      end
   end

   // ---------------------------------------------------------------
   // Latch events
   // ---------------------------------------------------------------
   // A polarity write flips the conditioned level with no pin movement;
   // the edge that follows in the next cycle is not a switch event, so
   // that side's capture is held off for one cycle
   wire [1:0] pol_next = REG_REQ_IN.wdata[CFG_POL_RIGHT:CFG_POL_LEFT];
   wire [1:0] pol_now  = config_q[CFG_POL_RIGHT:CFG_POL_LEFT];
   wire [1:0] pol_flip = wr_config ? (pol_next ^ pol_now) : 2'b00;

   // Configured edges that load the latch registers
   wire cap_left  = !pol_flip_q[0] &&
                    ((left_rise  && config_q[CFG_LATCH_L_ACT])
                  || (left_fall  && config_q[CFG_LATCH_L_INACT]));
   wire cap_right = !pol_flip_q[1] &&
                    ((right_rise && config_q[CFG_LATCH_R_ACT])
                  || (right_fall && config_q[CFG_LATCH_R_INACT]));

   // Either side loads the shared latch registers and the strobe
   wire cap_any   = cap_left || cap_right;

   // A stop is in force while the registered command is not run; the
   // event bits report an enabled switch that is active meanwhile
   wire stop_active    = (cmd_q != MOTION_RUN);
   wire left_stop_evt  = left_en  && stop_active;
   wire right_stop_evt = right_en && stop_active;

   // Status word assembled from live state and sticky flags
   wire [FLAGS_WIDTH-1:0] flags = {
      stall_evt_q,
      right_stop_evt,
      left_stop_evt,
      latch_right_q,
      latch_left_q,
      right_act,
      left_act
   };

   // Read data mux; write-only limits and unmapped addresses read zero
   wire [31:0] flags_word  = {{(32-FLAGS_WIDTH){1'b0}}, flags};
   wire [31:0] config_word = {{(32-CONFIG_WIDTH){1'b0}}, config_q};
   wire [31:0] rdata_d =
      rd_flags  ? flags_word  :
      rd_config ? config_word :
      32'h0000_0000;

   // ---------------------------------------------------------------
   // Configuration and limit registers
   // ---------------------------------------------------------------
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN) begin
         config_q      <= CONFIG_RESET;
         limit_left_q  <= POS_WIDTH'(LIMIT_RESET);
         limit_right_q <= POS_WIDTH'(LIMIT_RESET);
      end else begin
         if (wr_config) begin
            config_q <= REG_REQ_IN.wdata[CONFIG_WIDTH-1:0];
         end
         // Limit words have no read path; software keeps its own copy
         if (wr_lim_l) begin
            limit_left_q <= REG_REQ_IN.wdata[POS_WIDTH-1:0];
         end
         if (wr_lim_r) begin
            limit_right_q <= REG_REQ_IN.wdata[POS_WIDTH-1:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Sticky flags: set wins over clear-on-read
   // ---------------------------------------------------------------
   // A read and a new event in one cycle leave the flag set, so the
   // event is reported by the next read rather than lost
   wire stall_evt_set = stall_hit && MOVING_IN;

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN) begin
         latch_left_q  <= 1'b0;
         latch_right_q <= 1'b0;
         stall_evt_q   <= 1'b0;
      end else begin
         latch_left_q  <= cap_left || (latch_left_q && !rd_flags);
         latch_right_q <= cap_right ||
                          (latch_right_q && !rd_flags);
         stall_evt_q   <= stall_evt_set ||
                          (stall_evt_q && !rd_flags);
      end
   end

   // ---------------------------------------------------------------
   // Position capture and outputs
   // ---------------------------------------------------------------
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN) begin
         ramp_latch_q <= '0;
         enc_latch_q  <= '0;
         strobe_q     <= 1'b0;
         pol_flip_q   <= 2'b00;
         rdata_q      <= 32'h0000_0000;
         cmd_q        <= MOTION_RUN;
      end else begin
         strobe_q <= cap_any;
         rdata_q  <= rdata_d;
         cmd_q    <= cmd_d;
         pol_flip_q <= pol_flip;
         if (cap_any) begin
            ramp_latch_q <= RAMP_POS_IN;
         end
         // Encoder word only when enabled; otherwise it keeps its value
         if (cap_any && config_q[CFG_LATCH_ENC]) begin
            enc_latch_q <= ENC_POS_IN;
         end
      end
   end

   // Outputs come straight from flip-flops
   assign REG_RDATA_OUT    = rdata_q;
   assign MOTION_CMD_OUT   = cmd_q;
   assign RAMP_LATCH_OUT   = ramp_latch_q;
   assign ENC_LATCH_OUT    = enc_latch_q;
   assign LATCH_STROBE_OUT = strobe_q;

endmodule : reference_switch_stop_logic

// ---- core/refsw_pkg.sv ----
// Package: register map, field positions and carrier types for stop logic
package refsw_pkg;

   // ---------------------------------------------------------------
   // Register addresses
   // ---------------------------------------------------------------
   localparam logic [6:0] ADDR_CONFIG      = 7'h40;
   localparam logic [6:0] ADDR_FLAGS       = 7'h41;
   localparam logic [6:0] ADDR_LIMIT_LEFT  = 7'h42;
   localparam logic [6:0] ADDR_LIMIT_RIGHT = 7'h43;

   // ---------------------------------------------------------------
   // Widths and reset values
   // ---------------------------------------------------------------
   localparam int          CONFIG_WIDTH = 14;
   localparam int          FLAGS_WIDTH  = 7;
   localparam logic [13:0] CONFIG_RESET = 14'h0000;
   localparam logic [31:0] LIMIT_RESET  = 32'h0000_0000;

   // ---------------------------------------------------------------
   // Configuration field positions
   // ---------------------------------------------------------------
   localparam int CFG_EN_LEFT        = 0;
   localparam int CFG_EN_RIGHT       = 1;
   localparam int CFG_POL_LEFT       = 2;
   localparam int CFG_POL_RIGHT      = 3;
   localparam int CFG_EXCHANGE       = 4;
   localparam int CFG_RAMPED_HALT    = 5;
   localparam int CFG_LIM_LEFT       = 6;
   localparam int CFG_LIM_RIGHT      = 7;
   localparam int CFG_LATCH_L_ACT    = 8;
   localparam int CFG_LATCH_L_INACT  = 9;
   localparam int CFG_LATCH_R_ACT    = 10;
   localparam int CFG_LATCH_R_INACT  = 11;
   localparam int CFG_LATCH_ENC      = 12;
   localparam int CFG_STALL_HALT     = 13;

   // ---------------------------------------------------------------
   // Status field positions
   // ---------------------------------------------------------------
   localparam int FLG_SW_LEFT     = 0;
   localparam int FLG_SW_RIGHT    = 1;
   localparam int FLG_LATCH_LEFT  = 2;
   localparam int FLG_LATCH_RIGHT = 3;
   localparam int FLG_STOP_LEFT   = 4;
   localparam int FLG_STOP_RIGHT  = 5;
   localparam int FLG_STALL       = 6;

   // ---------------------------------------------------------------
   // Carrier types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [6:0]  addr;
      logic [31:0] wdata;
   } reg_req_type;

   typedef enum logic [1:0] {
      MOTION_RUN,
      MOTION_HARD_STOP,
      MOTION_RAMP_STOP
   } motion_cmd_type;

endpackage : refsw_pkg

// ---- core/refsw_edge.sv ----
// Switch conditioner: polarity and edge detection for one input
`timescale 1ns/1ps
module refsw_edge (
   input  wire logic SYS_CLK_IN,
   input  wire logic RST_B_IN,
   input  wire logic raw_in,
   input  wire logic invert_in,
   output logic      active_out,
   output logic      rise_out,
   output logic      fall_out
);
   logic prev_q;

   // Polarity: invert set means a low pin is the active state
   assign active_out = raw_in ^ invert_in;
   assign rise_out   = active_out & ~prev_q;
   assign fall_out   = ~active_out & prev_q;

   // Previous state for edge detection
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= active_out;
      end
   end
endmodule : refsw_edge

// ---- tb/refsw_monitor.sv ----
// Checker: port-level properties of the reference switch stop logic
`timescale 1ns/1ps
module refsw_monitor
   import refsw_pkg::*;
#(
   parameter int POS_WIDTH = 32
) (
   input wire logic                   SYS_CLK_IN,
   input wire logic                   RST_B_IN,
   input wire refsw_pkg::reg_req_type REG_REQ_IN,
   input wire logic [31:0]            REG_RDATA_OUT,
   input wire logic                   STOP_LEFT_IN,
   input wire logic                   STOP_RIGHT_IN,
   input wire logic                   DRIVER_STALL_IN,
   input wire logic                   DIR_NEGATIVE_IN,
   input wire logic                   MOVING_IN,
   input wire logic [POS_WIDTH-1:0]   RAMP_POS_IN,
   input wire logic [POS_WIDTH-1:0]   ENC_POS_IN,
   input wire logic [POS_WIDTH-1:0]   STOP_DIST_IN,
   input wire refsw_pkg::motion_cmd_type MOTION_CMD_OUT,
   input wire logic [POS_WIDTH-1:0]   RAMP_LATCH_OUT,
   input wire logic [POS_WIDTH-1:0]   ENC_LATCH_OUT,
   input wire logic                   LATCH_STROBE_OUT
);
   import refsw_pkg::*;
   // ---------------------------------------------------------------
   // Shadow configuration and stop cause decode
   // ---------------------------------------------------------------
   logic [13:0] cfg_q;
   logic [13:0] cfg_d;
   logic        cfg_wr, neg, hit, free, stall, rd_lim;
   assign cfg_wr = REG_REQ_IN.wr && (REG_REQ_IN.addr == ADDR_CONFIG);
   assign cfg_d  = cfg_wr ? REG_REQ_IN.wdata[13:0] : cfg_q;
   assign neg    = DIR_NEGATIVE_IN ^ cfg_q[4];
   assign hit    = MOVING_IN && ((cfg_q[0] && (STOP_LEFT_IN ^ cfg_q[2]) &&
                   neg) || (cfg_q[1] && (STOP_RIGHT_IN ^ cfg_q[3]) && !neg));
   assign stall  = cfg_q[13] && DRIVER_STALL_IN;
   assign free   = !hit && (cfg_q[7:6] == 2'b00) && !stall;
   assign rd_lim = REG_REQ_IN.rd && (REG_REQ_IN.addr[6:1] == 6'h21);
   // Shadow register follows writes to the configuration address
   always_ff @(posedge SYS_CLK_IN) cfg_q <= RST_B_IN ? cfg_d : 14'h0000;

   default clocking mon_cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RST_B_IN);

   property p_idle; !$past(REG_REQ_IN.rd) |-> REG_RDATA_OUT == 0; endproperty
   a_idle: assert property (p_idle) else $error("read data not zero");
   property p_wo; rd_lim |=> REG_RDATA_OUT == 32'h0000_0000; endproperty
   a_wo: assert property (p_wo) else $error("limit readable");
   property p_hard;
      hit [*3] ##0 !cfg_q[5] |-> MOTION_CMD_OUT == MOTION_HARD_STOP;
   endproperty
   a_hard: assert property (p_hard) else $error("no hard stop");
   property p_ramp;
      hit [*3] ##0 cfg_q[5] |-> MOTION_CMD_OUT == MOTION_RAMP_STOP;
   endproperty
   a_ramp: assert property (p_ramp) else $error("no ramp stop");
   property p_free; free [*3] |-> MOTION_CMD_OUT == MOTION_RUN; endproperty
   a_free: assert property (p_free) else $error("stop without cause");
   property p_stall; (stall && MOVING_IN) [*3] |-> MOTION_CMD_OUT != MOTION_RUN; endproperty
   a_stall: assert property (p_stall) else $error("no stall stop");
   property p_latch;
      LATCH_STROBE_OUT |-> RAMP_LATCH_OUT == $past(RAMP_POS_IN);
   endproperty
   a_latch: assert property (p_latch) else $error("bad ramp latch");
   property p_noenc; LATCH_STROBE_OUT && !cfg_q[12] |-> $stable(ENC_LATCH_OUT); endproperty
   a_noenc: assert property (p_noenc) else $error("encoder latched");

   c_hard: cover property (MOTION_CMD_OUT == MOTION_HARD_STOP);
   c_ramp: cover property (MOTION_CMD_OUT == MOTION_RAMP_STOP);
   c_strobe: cover property (LATCH_STROBE_OUT && cfg_q[12]);
endmodule : refsw_monitor

bind reference_switch_stop_logic refsw_monitor #(.POS_WIDTH(POS_WIDTH)) u_mon (
   .SYS_CLK_IN(SYS_CLK_IN), .RST_B_IN(RST_B_IN), .REG_REQ_IN(REG_REQ_IN),
   .REG_RDATA_OUT(REG_RDATA_OUT), .STOP_LEFT_IN(STOP_LEFT_IN),
   .STOP_RIGHT_IN(STOP_RIGHT_IN), .DRIVER_STALL_IN(DRIVER_STALL_IN),
   .DIR_NEGATIVE_IN(DIR_NEGATIVE_IN), .MOVING_IN(MOVING_IN),
   .RAMP_POS_IN(RAMP_POS_IN), .ENC_POS_IN(ENC_POS_IN),
   .STOP_DIST_IN(STOP_DIST_IN), .MOTION_CMD_OUT(MOTION_CMD_OUT),
   .RAMP_LATCH_OUT(RAMP_LATCH_OUT), .ENC_LATCH_OUT(ENC_LATCH_OUT),
   .LATCH_STROBE_OUT(LATCH_STROBE_OUT));

// ---- tb/refsw_partner.sv ----
// Model of the two stop switches and the driver stall line
`timescale 1ns/1ps
module refsw_partner (
   input  wire logic left_closed_in,
   input  wire logic right_closed_in,
   input  wire logic left_low_in,
   input  wire logic right_low_in,
   input  wire logic stall_in,
   output logic      left_pin_out,
   output logic      right_pin_out,
   output logic      stall_pin_out
);
   // A low-wired switch pulls its line low when closed
   assign left_pin_out  = left_closed_in ^ left_low_in;
   assign right_pin_out = right_closed_in ^ right_low_in;
   assign stall_pin_out = stall_in;
endmodule : refsw_partner

// ---- tb/reference_switch_stop_logic_bench.sv ----
// Testbench: register and stop scenarios for the stop logic
`timescale 1ns/1ps
module reference_switch_stop_logic_bench;
   import refsw_pkg::*;
   logic           clk, rst_b, lc, rc, ll, rl, st, dn, mv, lp, rp, sp, stb;
   logic [31:0]    rdata, rpos, epos, sdist, rlat, elat, d;
   reg_req_type    req;
   motion_cmd_type cmd;
   int             n_errors = 0;
   int             cmp_count = 0;

   always #50 clk = ~clk;

   refsw_partner model (.left_closed_in(lc), .right_closed_in(rc),
      .left_low_in(ll), .right_low_in(rl), .stall_in(st),
      .left_pin_out(lp), .right_pin_out(rp), .stall_pin_out(sp));
   reference_switch_stop_logic #(.POS_WIDTH(32)) dut (
      .SYS_CLK_IN(clk), .RST_B_IN(rst_b), .REG_REQ_IN(req),
      .REG_RDATA_OUT(rdata), .STOP_LEFT_IN(lp), .STOP_RIGHT_IN(rp),
      .DRIVER_STALL_IN(sp), .DIR_NEGATIVE_IN(dn), .MOVING_IN(mv),
      .RAMP_POS_IN(rpos), .ENC_POS_IN(epos), .STOP_DIST_IN(sdist),
      .MOTION_CMD_OUT(cmd), .RAMP_LATCH_OUT(rlat), .ENC_LATCH_OUT(elat),
      .LATCH_STROBE_OUT(stb));

   // Compare one value and count it
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // One-cycle register write, then one idle cycle
   task automatic wr(input logic [6:0] a, input logic [31:0] v);
      @(negedge clk) req = '{1'b1, 1'b0, a, v};
      @(negedge clk) req = '0;
   endtask : wr
   // One-cycle register read, data taken the cycle after
   task automatic rd(input logic [6:0] a, output logic [31:0] v);
      @(negedge clk) req = '{1'b0, 1'b1, a, 32'h0000_0000};
      @(negedge clk) req = '0;
      v = rdata;
   endtask : rd
   // Print counts and verdict, then stop
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude

   // Watchdog against a hang
   initial begin
      #100_000;
      n_errors++;
      conclude();
   end

   // Main sequence
   initial begin
      clk = 0; rst_b = 0; req = '0; {lc, rc, ll, rl, st, dn, mv} = '0;
      rpos = '0; epos = '0; sdist = '0;
      repeat (3) @(negedge clk);
      rst_b = 1;
      rd(ADDR_CONFIG, d);
      check(d, 32'h0000_0000);
      wr(ADDR_LIMIT_LEFT, 32'h1234_5678);
      rd(ADDR_LIMIT_LEFT, d);
      check(d, 32'h0000_0000);
      rd(7'h10, d);
      check(d, 32'h0000_0000);
      $display("reset test done");
      wr(ADDR_CONFIG, 32'h0000_0101);
      dn = 1; mv = 1; rpos = 32'h0000_2468; lc = 1;
      epos = 32'h0000_1111;
      repeat (4) @(negedge clk);
      check({30'h0, cmd}, {30'h0, MOTION_HARD_STOP});
      check(rlat, 32'h0000_2468);
      check(elat, 32'h0000_0000);
      rd(ADDR_FLAGS, d);
      check(d, 32'h0000_0015);
      rd(ADDR_FLAGS, d);
      check(d, 32'h0000_0011);
      wr(ADDR_CONFIG, 32'h0000_0201);
      rpos = 32'h0000_1357; lc = 0;
      repeat (4) @(negedge clk);
      check(rlat, 32'h0000_1357);
      check({30'h0, cmd}, {30'h0, MOTION_RUN});
      $display("hard stop test done");
      rl = 1;
      wr(ADDR_CONFIG, 32'h0000_0008);
      wr(ADDR_CONFIG, 32'h0000_183A);
      rc = 1;
      repeat (4) @(negedge clk);
      check({30'h0, cmd}, {30'h0, MOTION_RAMP_STOP});
      rd(ADDR_FLAGS, d);
      check(d, 32'h0000_0026);
      rpos = 32'h0000_000A; epos = 32'h0000_000B; rc = 0;
      repeat (4) @(negedge clk);
      check(rlat, 32'h0000_000A);
      check(elat, 32'h0000_000B);
      dn = 0; rc = 1;
      repeat (4) @(negedge clk);
      check({30'h0, cmd}, {30'h0, MOTION_RUN});
      rc = 0;
      wr(ADDR_CONFIG, 32'h0000_0008);
      dn = 1; lc = 1;
      repeat (4) @(negedge clk);
      check({30'h0, cmd}, {30'h0, MOTION_RUN});
      lc = 0;
      $display("polarity and direction test done");
      wr(ADDR_CONFIG, 32'h0000_2008);
      st = 1;
      repeat (4) @(negedge clk);
      check({31'h0, cmd === MOTION_RUN}, 32'h0000_0000);
      rd(ADDR_FLAGS, d);
      check(d & 32'h0000_0040, 32'h0000_0040);
      st = 0;
      rd(ADDR_FLAGS, d);
      rd(ADDR_FLAGS, d);
      check(d & 32'h0000_0040, 32'h0000_0000);
      $display("stall test done");
      wr(ADDR_CONFIG, 32'h0000_0080);
      wr(ADDR_LIMIT_RIGHT, 32'h0000_1000);
      dn = 0; rpos = 32'h0000_0800; sdist = 32'h0000_0200;
      repeat (4) @(negedge clk);
      check({30'h0, cmd}, {30'h0, MOTION_RUN});
      rpos = 32'h0000_0F00;
      repeat (4) @(negedge clk);
      check({30'h0, cmd}, {30'h0, MOTION_RAMP_STOP});
      rpos = 32'h0000_1000;
      repeat (4) @(negedge clk);
      check({30'h0, cmd}, {30'h0, MOTION_HARD_STOP});
      $display("virtual limit test done");
      conclude();
   end
endmodule : reference_switch_stop_logic_bench
